// [core/bau_pkg.sv]
// Package of constants and types for the byte ALU datapath and its register window.
package bau_pkg;
   localparam int unsigned DATA_W = 8;
   // Register byte addresses.
   localparam logic [11:0] OFF_OPER = 12'h000;
   localparam logic [11:0] OFF_ACC  = 12'h004;
   localparam logic [11:0] OFF_FLAG = 12'h008;
   localparam logic [11:0] OFF_MEMA = 12'h00C;
   localparam logic [11:0] OFF_MEMD = 12'h010;
   localparam logic [11:0] OFF_IOD  = 12'h014;
   localparam logic [11:0] OFF_STAT = 12'h018;
   // Field positions in the operation register.
   localparam int unsigned OP_LSB  = 0;
   localparam int unsigned IMM_LSB = 8;
   localparam int unsigned GO_BIT  = 31;
   // Field positions in the flag register.
   localparam int unsigned NULL_BIT = 0;
   localparam int unsigned WRAP_BIT = 1;
   localparam int unsigned HALF_BIT = 2;
   localparam int unsigned SIGN_BIT = 3;
   // Reset values and memory depth.
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic [3:0] FLAG_RST = 4'h0;
   localparam logic [7:0] MEM_RST  = 8'h00;
   localparam logic [7:0] IOD_RST  = 8'h00;
   localparam int unsigned MEM_DEPTH = 16;
   // Operation codes.
   typedef enum logic [4:0] {
      OP_INC_M   = 5'h00, OP_DEC_M  = 5'h01, OP_CLR_M  = 5'h02,
      OP_SHR_A   = 5'h03, OP_ROR_A  = 5'h04, OP_SHR_M  = 5'h05, OP_ROR_M = 5'h06,
      OP_SHL_A   = 5'h07, OP_ROL_A  = 5'h08, OP_SHL_M  = 5'h09, OP_ROL_M = 5'h0A,
      OP_SWAP_A  = 5'h0B,
      OP_AND_AI  = 5'h0C, OP_AND_AM = 5'h0D, OP_AND_MA = 5'h0E,
      OP_OR_AI   = 5'h0F, OP_OR_AM  = 5'h10, OP_OR_MA  = 5'h11,
      OP_XOR_AI  = 5'h12, OP_XOR_AM = 5'h13, OP_XOR_MA = 5'h14, OP_XOR_IO = 5'h15,
      OP_NOT_A   = 5'h16, OP_NOT_M  = 5'h17, OP_NEG_A  = 5'h18, OP_NEG_M = 5'h19
   } bau_op_t;
endpackage

// [core/bau_alu.sv]
// Combinational 8-bit unary, shift and logic unit with per-operation flag update.
`timescale 1ns/1ps
module bau_alu (
   // Operation and operands
   input  wire logic [4:0] op,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] mem,
   input  wire logic [7:0] imm,
   input  wire logic [7:0] iod,
   input  wire logic [3:0] flg_in,
   // Results
   output logic      [7:0] res,
   output logic      [3:0] flg_out,
   output logic            wr_acc,
   output logic            wr_mem,
   output logic            wr_io
);
   logic [8:0] sum;
   logic [4:0] half;
   logic       wrap_in;
   logic       arith;
   logic       logic_z;

   always_comb begin
      wrap_in = flg_in[bau_pkg::WRAP_BIT];
      res     = acc;
      flg_out = flg_in;
      wr_acc  = 1'b0;
      wr_mem  = 1'b0;
      wr_io   = 1'b0;
      sum     = 9'h000;
      half    = 5'h00;
      arith   = 1'b0;
      logic_z = 1'b0;
      case (op)
         bau_pkg::OP_INC_M: begin
            sum = {1'b0, mem} + 9'h001; // RULE_01
            half = {1'b0, mem[3:0]} + 5'h01;
            res = sum[7:0];
            wr_mem = 1'b1;
            arith = 1'b1;
            flg_out[bau_pkg::SIGN_BIT] = ~mem[7] & res[7]; // RULE_21
         end
         bau_pkg::OP_DEC_M: begin
            // Borrow shows as a clear carry out of mem + 0xFF, so it is inverted.
            sum = {1'b0, mem} + 9'h0FF; // RULE_02
            half = {1'b0, mem[3:0]} + 5'h0F;
            sum[8] = ~sum[8];
            half[4] = ~half[4];
            res = sum[7:0];
            wr_mem = 1'b1;
            arith = 1'b1;
            flg_out[bau_pkg::SIGN_BIT] = mem[7] & ~res[7]; // RULE_21
         end
         bau_pkg::OP_CLR_M: begin
            res = 8'h00; // RULE_03
            wr_mem = 1'b1;
         end
         bau_pkg::OP_SHR_A: begin
            res = {1'b0, acc[7:1]}; // RULE_04
            flg_out[bau_pkg::WRAP_BIT] = acc[0];
            wr_acc = 1'b1;
         end
         bau_pkg::OP_ROR_A: begin
            res = {wrap_in, acc[7:1]}; // RULE_05
            flg_out[bau_pkg::WRAP_BIT] = acc[0];
            wr_acc = 1'b1;
         end
         bau_pkg::OP_SHR_M: begin
            res = {1'b0, mem[7:1]}; // RULE_06
            flg_out[bau_pkg::WRAP_BIT] = mem[0];
            wr_mem = 1'b1;
         end
         bau_pkg::OP_ROR_M: begin
            res = {wrap_in, mem[7:1]}; // RULE_07
            flg_out[bau_pkg::WRAP_BIT] = mem[0];
            wr_mem = 1'b1;
         end
         bau_pkg::OP_SHL_A: begin
            res = {acc[6:0], 1'b0}; // RULE_08
            flg_out[bau_pkg::WRAP_BIT] = acc[7];
            wr_acc = 1'b1;
         end
         bau_pkg::OP_ROL_A: begin
            res = {acc[6:0], wrap_in}; // RULE_09
            flg_out[bau_pkg::WRAP_BIT] = acc[7];
            wr_acc = 1'b1;
         end
         bau_pkg::OP_SHL_M: begin
            res = {mem[6:0], 1'b0}; // RULE_10
            flg_out[bau_pkg::WRAP_BIT] = mem[7];
            wr_mem = 1'b1;
         end
         bau_pkg::OP_ROL_M: begin
            res = {mem[6:0], wrap_in}; // RULE_11
            flg_out[bau_pkg::WRAP_BIT] = mem[7];
            wr_mem = 1'b1;
         end
         bau_pkg::OP_SWAP_A: begin
            res = {acc[3:0], acc[7:4]}; // RULE_12
            wr_acc = 1'b1;
         end
         bau_pkg::OP_AND_AI: begin res = acc & imm; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_13
         bau_pkg::OP_AND_AM: begin res = acc & mem; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_13
         bau_pkg::OP_AND_MA: begin res = acc & mem; wr_mem = 1'b1; logic_z = 1'b1; end // RULE_13
         bau_pkg::OP_OR_AI:  begin res = acc | imm; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_14
         bau_pkg::OP_OR_AM:  begin res = acc | mem; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_14
         bau_pkg::OP_OR_MA:  begin res = acc | mem; wr_mem = 1'b1; logic_z = 1'b1; end // RULE_14
         bau_pkg::OP_XOR_AI: begin res = acc ^ imm; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_15
         bau_pkg::OP_XOR_AM: begin res = acc ^ mem; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_15
         bau_pkg::OP_XOR_MA: begin res = acc ^ mem; wr_mem = 1'b1; logic_z = 1'b1; end // RULE_15
         bau_pkg::OP_XOR_IO: begin
            res = acc ^ iod; // RULE_16
            wr_io = 1'b1;
         end
         bau_pkg::OP_NOT_A: begin res = ~acc; wr_acc = 1'b1; logic_z = 1'b1; end // RULE_17
         bau_pkg::OP_NOT_M: begin res = ~mem; wr_mem = 1'b1; logic_z = 1'b1; end // RULE_18
         bau_pkg::OP_NEG_A: begin
            res = 8'h00 - acc; // RULE_19
            wr_acc = 1'b1;
            logic_z = 1'b1;
         end
         bau_pkg::OP_NEG_M: begin
            res = 8'h00 - mem; // RULE_20
            wr_mem = 1'b1;
            logic_z = 1'b1;
         end
         default: begin
            res = acc;
         end
      endcase
      if (arith) begin
         flg_out[bau_pkg::NULL_BIT] = (res == 8'h00); // RULE_21
         flg_out[bau_pkg::WRAP_BIT] = sum[8];
         flg_out[bau_pkg::HALF_BIT] = half[4];
      end
      if (logic_z) begin
         flg_out[bau_pkg::NULL_BIT] = (res == 8'h00); // RULE_21
      end
   end
endmodule // bau_alu

// [core/bau_top.sv]
// AHB-Lite wrapped byte ALU datapath with accumulator, flags, byte memory and IO register.
//
// Contract
// RULE_01: Increment memory byte, update all four flags.
// RULE_02: Decrement memory byte, update all four flags.
// RULE_03: Clear memory byte, flags untouched.
// RULE_04: Accumulator right shift, zero in, wrap gets bit0.
// RULE_05: Accumulator rotate right through wrap flag.
// RULE_06: Memory right shift, zero in, wrap gets bit0.
// RULE_07: Memory rotate right through wrap flag.
// RULE_08: Accumulator left shift, zero in, wrap gets bit7.
// RULE_09: Accumulator rotate left through wrap flag.
// RULE_10: Memory left shift, zero in, wrap gets bit7.
// RULE_11: Memory rotate left through wrap flag.
// RULE_12: Swap accumulator nibbles, flags untouched.
// RULE_13: AND with immediate or memory, null only.
// RULE_14: OR with immediate or memory, null only.
// RULE_15: XOR with immediate or memory, null only.
// RULE_16: XOR accumulator into IO register, flags untouched.
// RULE_17: Invert accumulator, null flag only.
// RULE_18: Invert memory byte, null flag only.
// RULE_19: Negate accumulator, null flag only.
// RULE_20: Negate memory byte, null flag only.
// RULE_21: Flags mean zero, carry, half carry, overflow.
// RULE_22: Eight-bit operands; memory read-modify-write same address.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module bau_top #(
   parameter int unsigned MEM_DEPTH = bau_pkg::MEM_DEPTH
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Datapath state
   output logic      [7:0]  acc_o,
   output logic      [3:0]  flags_o,
   output logic      [7:0]  io_data_o,
   output logic             done_o
);
   localparam int unsigned AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

   logic [7:0]  mem_q [MEM_DEPTH];
   logic [7:0]  acc_q;
   logic [3:0]  flg_q;
   logic [7:0]  iod_q;
   logic [4:0]  op_q;
   logic [7:0]  imm_q;
   logic [AW-1:0] addr_q;
   logic        go_q;
   logic        done_q;
   logic [31:0] hrdata_q;
   logic        ph_wr_q;
   logic        ph_rd_q;
   logic [11:0] ph_addr_q;

   logic        ap_valid;
   logic [7:0]  mem_rd;
   logic [7:0]  alu_res;
   logic [3:0]  alu_flg;
   logic        alu_wa;
   logic        alu_wm;
   logic        alu_wi;
   logic        sw_wr;
   logic [31:0] rd_mux;

   assign ap_valid = hsel & hready & htrans[1];
   assign sw_wr    = ph_wr_q & ~go_q;
   assign mem_rd   = mem_q[addr_q];

   bau_alu u_alu (
      .op      (op_q),
      .acc     (acc_q),
      .mem     (mem_rd),
      .imm     (imm_q),
      .iod     (iod_q),
      .flg_in  (flg_q),
      .res     (alu_res),
      .flg_out (alu_flg),
      .wr_acc  (alu_wa),
      .wr_mem  (alu_wm),
      .wr_io   (alu_wi)
   );

   // Capture the address phase; a write data phase completes with zero wait states, a read data phase with one.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q   <= 1'b0;
         ph_rd_q   <= 1'b0;
         ph_addr_q <= 12'h000;
      end else begin
         ph_wr_q   <= ap_valid & hwrite;
         ph_rd_q   <= ap_valid & ~hwrite;
         ph_addr_q <= haddr[11:0];
      end
   end

   // Operation register; writing with the start bit set launches one operation.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_q  <= 5'h00;
         imm_q <= 8'h00;
         go_q  <= 1'b0;
      end else begin
         go_q <= 1'b0;
         if (ph_wr_q && ph_addr_q == bau_pkg::OFF_OPER) begin
            op_q  <= hwdata[bau_pkg::OP_LSB +: 5];
            imm_q <= hwdata[bau_pkg::IMM_LSB +: 8];
            go_q  <= hwdata[bau_pkg::GO_BIT];
         end
      end
   end

   // The operation executes in the single cycle after the start write, so the memory
   // byte is read, computed and written back at the same address in one step.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= bau_pkg::ACC_RST;
         flg_q <= bau_pkg::FLAG_RST;
         iod_q <= bau_pkg::IOD_RST;
      end else if (go_q) begin
         flg_q <= alu_flg; // RULE_21
         if (alu_wa) begin
            acc_q <= alu_res;
         end
         if (alu_wi) begin
            iod_q <= alu_res; // RULE_16
         end
      end else if (sw_wr) begin
         if (ph_addr_q == bau_pkg::OFF_ACC) begin
            acc_q <= hwdata[7:0];
         end
         if (ph_addr_q == bau_pkg::OFF_FLAG) begin
            flg_q <= hwdata[3:0];
         end
         if (ph_addr_q == bau_pkg::OFF_IOD) begin
            iod_q <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= '0;
      end else if (sw_wr && ph_addr_q == bau_pkg::OFF_MEMA) begin
         addr_q <= hwdata[AW-1:0];
      end
   end

   // Memory bytes are flip-flops indexed by the address register.
   genvar gi;
   generate
      for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               mem_q[gi] <= bau_pkg::MEM_RST;
            end else if (addr_q == AW'(gi)) begin
               if (go_q && alu_wm) begin
                  mem_q[gi] <= alu_res; // RULE_22
               end else if (sw_wr && ph_addr_q == bau_pkg::OFF_MEMD) begin
                  mem_q[gi] <= hwdata[7:0];
               end
            end
         end
      end
   endgenerate

   // Done is sticky until the next write to the operation register; a start wins over the clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_q <= 1'b0;
      end else if (go_q) begin
         done_q <= 1'b1;
      end else if (ph_wr_q && ph_addr_q == bau_pkg::OFF_OPER) begin
         done_q <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (ph_addr_q)
         bau_pkg::OFF_OPER: rd_mux = {24'h000000, 3'h0, op_q} | {16'h0000, imm_q, 8'h00};
         bau_pkg::OFF_ACC:  rd_mux = {24'h000000, acc_q};
         bau_pkg::OFF_FLAG: rd_mux = {28'h0000000, flg_q};
         bau_pkg::OFF_MEMA: rd_mux = 32'(addr_q);
         bau_pkg::OFF_MEMD: rd_mux = {24'h000000, mem_rd};
         bau_pkg::OFF_IOD:  rd_mux = {24'h000000, iod_q};
         bau_pkg::OFF_STAT: rd_mux = {31'h00000000, done_q};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is registered from the decoded address so hrdata comes from a flop;
   // it becomes valid one cycle after the data phase begins (one wait state) and
   // then holds until the next read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ph_rd_q) begin
         hrdata_q <= rd_mux;
      end
   end

   // Reads stall one cycle so the registered read data is in place when hready rises.
   logic hready_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hready_q <= 1'b1;
      end else begin
         hready_q <= ~(ap_valid & ~hwrite);
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hready_q;
   assign hresp     = 1'b0;
   assign acc_o     = acc_q;
   assign flags_o   = flg_q;
   assign io_data_o = iod_q;
   assign done_o    = done_q;
endmodule // bau_top

// [tb/bau_top_properties.sv]
// Concurrent checks of the byte ALU datapath seen at its top-level ports.
`timescale 1ns/1ps
module bau_top_properties #(
   parameter int unsigned MEM_DEPTH = 16
) (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Datapath state
   input wire logic [7:0]  acc_o,
   input wire logic [3:0]  flags_o,
   input wire logic [7:0]  io_data_o,
   input wire logic        done_o
);
   logic        aw_q;
   logic [11:0] aa_q;
   logic        go_q;
   logic [4:0]  op_q;
   logic [7:0]  imm_q;
   logic [7:0]  acc_p_q;
   logic [3:0]  flg_p_q;
   logic [7:0]  io_p_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // An operation runs the cycle after the start write, so go_q marks that cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aw_q <= 1'b0;
         aa_q <= 12'h000;
         go_q <= 1'b0;
         op_q <= 5'h00;
         imm_q <= 8'h00;
      end else begin
         go_q <= hready && aw_q && aa_q == bau_pkg::OFF_OPER && hwdata[31];
         if (hready && aw_q) begin
            op_q <= hwdata[4:0];
            imm_q <= hwdata[15:8];
         end
         if (hready) begin
            aw_q <= hsel && htrans[1] && hwrite;
            aa_q <= haddr[11:0];
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_p_q <= 8'h00;
         flg_p_q <= 4'h0;
         io_p_q <= 8'h00;
      end else begin
         acc_p_q <= acc_o;
         flg_p_q <= flags_o;
         io_p_q <= io_data_o;
      end
   end
   okay_resp_a: assert property (hresp == 1'b0) else $error("Response not OKAY.");
   read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong.");
   write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("Write stalled.");
   done_set_a: assert property (go_q |=> done_o) else $error("Done not set.");
   swap_nib_a: assert property (go_q && op_q == 5'h0B |=> acc_o == {acc_p_q[3:0], acc_p_q[7:4]}
      && $stable(flags_o)) else $error("Swap wrong.");
   shr_acc_a: assert property (go_q && op_q == 5'h03 |=> acc_o == {1'b0, acc_p_q[7:1]}
      && flags_o == {flg_p_q[3:2], acc_p_q[0], flg_p_q[0]}) else $error("Right shift wrong.");
   rol_acc_a: assert property (go_q && op_q == 5'h08 |=> acc_o == {acc_p_q[6:0], flg_p_q[1]}
      && flags_o[1] == acc_p_q[7]) else $error("Left rotate wrong.");
   neg_acc_a: assert property (go_q && op_q == 5'h18 |=> acc_o == 8'h00 - acc_p_q
      && flags_o == {flg_p_q[3:1], acc_o == 8'h00}) else $error("Negate wrong.");
   xor_io_a: assert property (go_q && op_q == 5'h15 |=> io_data_o == (acc_p_q ^ io_p_q)
      && flags_o == flg_p_q && acc_o == acc_p_q) else $error("IO xor wrong.");
   and_imm_a: assert property (go_q && op_q == 5'h0C |=> acc_o == (acc_p_q & imm_q)
      && flags_o == {flg_p_q[3:1], acc_o == 8'h00}) else $error("And wrong.");
   mem_only_a: assert property (go_q && op_q inside {[5'h00:5'h02], 5'h05, 5'h06, 5'h09, 5'h0A,
      5'h17, 5'h19} |=> acc_o == acc_p_q) else $error("Memory op hit acc.");
   clr_keep_a: assert property (go_q && op_q == 5'h02 |=> flags_o == flg_p_q)
      else $error("Clear changed flags.");
   swap_c: cover property (go_q && op_q == 5'h0B);
   read_c: cover property (hsel && hready && htrans[1] && !hwrite);
   xor_io_c: cover property (go_q && op_q == 5'h15);
endmodule // bau_top_properties
bind bau_top bau_top_properties #(.MEM_DEPTH(MEM_DEPTH)) u_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .acc_o(acc_o), .flags_o(flags_o),
   .io_data_o(io_data_o), .done_o(done_o));

// [tb/bau_top_tb.sv]
// Self-checking bench for the byte ALU datapath over AHB-Lite.
`timescale 1ns/1ps
module bau_top_tb;
   typedef struct packed {logic [7:0] a; logic [7:0] m; logic [7:0] io; logic [3:0] f;} bau_st_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:0]  acc_o;
   logic [3:0]  flags_o;
   logic [7:0]  io_data_o;
   logic        done_o;
   logic [31:0] seed = 32'h0000_3707;
   logic [31:0] rd;
   logic [31:0] r;
   logic [7:0]  imm;
   logic [7:0]  corner [6] = '{8'hFF, 8'h7F, 8'h80, 8'h00, 8'h0F, 8'h10};
   bau_st_t     s;
   bau_st_t     e;
   int          error_cnt = 0;
   int          comparisons = 0;
   bau_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .acc_o(acc_o), .flags_o(flags_o),
      .io_data_o(io_data_o), .done_o(done_o));
   initial begin
      forever #50 hclk = ~hclk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic bau_st_t model(input logic [4:0] op, input bau_st_t s, input logic [7:0] i);
      bau_st_t n;
      n = s;
      case (op)
         5'h00: n.m = s.m + 8'h01;
         5'h01: n.m = s.m - 8'h01;
         5'h02: n.m = 8'h00;
         5'h03: n.a = {1'b0, s.a[7:1]};
         5'h04: n.a = {s.f[1], s.a[7:1]};
         5'h05: n.m = {1'b0, s.m[7:1]};
         5'h06: n.m = {s.f[1], s.m[7:1]};
         5'h07: n.a = {s.a[6:0], 1'b0};
         5'h08: n.a = {s.a[6:0], s.f[1]};
         5'h09: n.m = {s.m[6:0], 1'b0};
         5'h0A: n.m = {s.m[6:0], s.f[1]};
         5'h0B: n.a = {s.a[3:0], s.a[7:4]};
         5'h0C: n.a = s.a & i;
         5'h0D: n.a = s.a & s.m;
         5'h0E: n.m = s.a & s.m;
         5'h0F: n.a = s.a | i;
         5'h10: n.a = s.a | s.m;
         5'h11: n.m = s.a | s.m;
         5'h12: n.a = s.a ^ i;
         5'h13: n.a = s.a ^ s.m;
         5'h14: n.m = s.a ^ s.m;
         5'h15: n.io = s.a ^ s.io;
         5'h16: n.a = ~s.a;
         5'h17: n.m = ~s.m;
         5'h18: n.a = 8'h00 - s.a;
         5'h19: n.m = 8'h00 - s.m;
         default: n = s;
      endcase
      if (op inside {[5'h03:5'h0A]})
         n.f[1] = op < 5'h07 ? (op < 5'h05 ? s.a[0] : s.m[0]) : (op < 5'h09 ? s.a[7] : s.m[7]);
      if (op inside {[5'h0C:5'h14], [5'h16:5'h19]})
         n.f[0] = ((op inside {5'h0E, 5'h11, 5'h14, 5'h17, 5'h19}) ? n.m : n.a) == 8'h00;
      if (op == 5'h00)
         n.f = {s.m == 8'h7F, s.m[3:0] == 4'hF, s.m == 8'hFF, n.m == 8'h00};
      if (op == 5'h01)
         n.f = {s.m == 8'h80, s.m[3:0] == 4'h0, s.m == 8'h00, n.m == 8'h00};
      return n;
   endfunction
   task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, ad};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #2_000_000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk(32'({acc_o, flags_o, io_data_o, done_o, hreadyout}), 32'h0000_0001, "reset");
      ahb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      for (int op = 0; op < 26; op++) begin
         for (int it = 0; it < 8; it++) begin
            r = rnd();
            s.m = it < 6 ? corner[it] : r[7:0];
            s.a = it[0] ? s.m : r[15:8];
            s.io = r[23:16];
            s.f = r[27:24];
            imm = it[1] ? s.a : r[31:24];
            ahb(1'b1, bau_pkg::OFF_ACC, {24'h0, s.a});
            ahb(1'b1, bau_pkg::OFF_FLAG, {28'h0, s.f});
            ahb(1'b1, bau_pkg::OFF_MEMA, {28'h0, r[3:0]});
            ahb(1'b1, bau_pkg::OFF_MEMD, {24'h0, s.m});
            ahb(1'b1, bau_pkg::OFF_IOD, {24'h0, s.io});
            e = model(op[4:0], s, imm);
            ahb(1'b1, bau_pkg::OFF_OPER, {1'b1, 15'h0, imm, 3'h0, op[4:0]});
            ahb(1'b0, bau_pkg::OFF_MEMD, 32'h0);
            chk(rd, {24'h0, e.m}, "memory byte");
            chk(32'({acc_o, flags_o, io_data_o, done_o}),
               32'({e.a, e.f, e.io, 1'b1}), "state");
            ahb(1'b0, bau_pkg::OFF_FLAG, 32'h0);
            chk(rd, {28'h0, e.f}, "flag read");
         end
      end
      ahb(1'b1, bau_pkg::OFF_OPER, 32'h0);
      ahb(1'b0, bau_pkg::OFF_STAT, 32'h0);
      chk(rd, 32'h0, "done cleared");
      ahb(1'b1, bau_pkg::OFF_OPER, 32'h8000_001F);
      ahb(1'b0, bau_pkg::OFF_STAT, 32'h0);
      chk(rd, 32'h1, "done set");
      chk(32'({acc_o, flags_o, io_data_o}), 32'({e.a, e.f, e.io}), "unused opcode");
      summarize();
   end
endmodule // bau_top_tb
